// >>> verilog/prs_defs.vh
`ifndef PRS_DEFS_VH
`define PRS_DEFS_VH
// Sequencer states
`define PRS_ST_NVM_RST   3'h0
`define PRS_ST_LOAD      3'h1
`define PRS_ST_IN        3'h2
`define PRS_ST_LUT       3'h3
`define PRS_ST_SEQ       3'h4
`define PRS_ST_POG       3'h5
`define PRS_ST_RUN       3'h6
// Trigger modes of the external reset
`define PRS_TRIG_LEVEL   2'h0
`define PRS_TRIG_RISE    2'h1
`define PRS_TRIG_FALL    2'h2
// Pin mode code meaning digital input
`define PRS_PIN_DIGIN    2'h1
// Default step lengths of the sequencer, clock cycles
`define PRS_LOAD_CYC         64
`define PRS_STEP_CYC         8
// Reference output lead before power-on-good, ns
`define PRS_VREF_LEAD_MIN_NS 3000
`define PRS_VREF_LEAD_MAX_NS 5000
`define PRS_CLK_NS           10
// Minimum lead rounds up; the maximum is not applied
`define PRS_VREF_LEAD_CYC \
  ((`PRS_VREF_LEAD_MIN_NS + `PRS_CLK_NS - 1) / `PRS_CLK_NS)
`endif

// >>> verilog/prs_edge_trig.v
`timescale 1ns/10ps
`include "prs_defs.vh"
module prs_edge_trig (
  // Clock and reset
  input  wire       core_clk,
  input  wire       sys_rst,
  // Trigger control
  input  wire [1:0] mode,
  input  wire       pin_level,
  // Event out
  output reg        fire
);
  reg prev_level;
  reg next_fire;

  always @* begin
    case (mode)
      `PRS_TRIG_LEVEL: next_fire = pin_level;
      `PRS_TRIG_RISE:  next_fire = pin_level & ~prev_level;
      `PRS_TRIG_FALL:  next_fire = ~pin_level & prev_level;
      default:         next_fire = 1'b0;
    endcase
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_level <= 1'b0;
      fire       <= 1'b0;
    end else begin
      prev_level <= pin_level;
      fire       <= next_fire;
    end
  end
endmodule

// >>> verilog/prs_sequencer.v
`timescale 1ns/10ps
`include "prs_defs.vh"
module prs_sequencer #(
  parameter LOAD_CYC   = `PRS_LOAD_CYC,
  parameter STEP_CYC   = `PRS_STEP_CYC,
  parameter VREF_CYC   = `PRS_VREF_LEAD_CYC
) (
  // Clock and reset
  input  wire       core_clk,
  input  wire       sys_rst,
  // Supply monitors
  input  wire       supply_on,
  input  wire       supply_below_2v7,
  input  wire       supply_det_off,
  // External reset pin and its configuration
  input  wire       ext_rst_pin,
  input  wire [1:0] ext_pin_mode,
  input  wire       ext_rst_en,
  input  wire [1:0] ext_trig_mode,
  input  wire       pipe_rst_on_pog,
  // Fabric inverters
  input  wire       inv_a_in,
  input  wire       inv_b_in,
  // Status and releases
  output reg        cfg_load,
  output reg        cfg_valid,
  output reg        input_cell_rel,
  output reg        lut_rel,
  output reg        store_cell_rel,
  output reg        pipe_delay_rel,
  output reg        power_on_good,
  output reg        vref_drive,
  output reg        pin_oe_n,
  output reg        pin_oe_follow,
  output reg        supply_level_detector,
  output reg        fabric_inverter_a,
  output reg        fabric_inverter_b
);
  localparam CW = 16;

  reg  [2:0]    state;
  reg  [2:0]    next_state;
  reg  [CW-1:0] cnt;
  reg  [CW-1:0] next_cnt;
  reg           ext_active;
  reg           next_ext_active;
  reg           next_pipe_rel;
  wire          ext_fire;
  wire          ext_allowed;
  wire          next_cold;
  wire          next_run;
  wire          ext_entry;

  assign ext_allowed = ext_rst_en &
                       (ext_pin_mode == `PRS_PIN_DIGIN);

  // Configuration is not usable while memory resets or loads
  assign next_cold = (next_state == `PRS_ST_NVM_RST) ||
                     (next_state == `PRS_ST_LOAD);
  assign next_run  = (next_state == `PRS_ST_RUN);
  // Leaving RUN for IN can only be an external reset
  assign ext_entry = (state == `PRS_ST_RUN) &&
                     (next_state == `PRS_ST_IN);

  prs_edge_trig u_trig (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .mode      (ext_trig_mode),
    .pin_level (ext_rst_pin & ext_allowed),
    .fire      (ext_fire)
  );

  always @* begin
    next_state = state;
    next_cnt   = cnt + {{(CW-1){1'b0}}, 1'b1};
    case (state)
      `PRS_ST_NVM_RST: begin
        // Memory clears for one cycle; every cell reads low
        next_state = `PRS_ST_LOAD;
        next_cnt   = {CW{1'b0}};
      end
      `PRS_ST_LOAD: begin
        // Cells held and pins undriven while memory loads
        if (cnt == LOAD_CYC[CW-1:0] - 1'b1) begin
          next_state = `PRS_ST_IN;
          next_cnt   = {CW{1'b0}};
        end
      end
      `PRS_ST_IN, `PRS_ST_LUT: begin
        // Inputs first, then lookup tables, one step each
        if (cnt == STEP_CYC[CW-1:0] - 1'b1) begin
          next_state = state + 3'h1;
          next_cnt   = {CW{1'b0}};
        end
      end
      `PRS_ST_SEQ: begin
        // Storage cells and pipe delays leave reset after this step
        if (cnt == STEP_CYC[CW-1:0] - 1'b1) begin
          next_state = `PRS_ST_POG;
          next_cnt   = {CW{1'b0}};
        end
      end
      `PRS_ST_POG: begin
        // Reference pin is already driving; wait out its lead time
        if (cnt == VREF_CYC[CW-1:0] - 1'b1) begin
          next_state = `PRS_ST_RUN;
          next_cnt   = {CW{1'b0}};
        end
      end
      `PRS_ST_RUN: begin
        // Only an allowed external event restarts the release chain
        next_cnt = {CW{1'b0}};
        if (ext_fire) begin
          next_state = `PRS_ST_IN;
        end
      end
      default: begin
        next_state = `PRS_ST_NVM_RST;
        next_cnt   = {CW{1'b0}};
      end
    endcase
    // Losing the supply restarts from a memory reset
    if (!supply_on) begin
      next_state = `PRS_ST_NVM_RST;
      next_cnt   = {CW{1'b0}};
    end
  end

  // An external reset is in progress until RUN is reached again
  always @* begin
    next_ext_active = ext_active;
    if (next_cold) begin
      next_ext_active = 1'b0;
    end else if (ext_entry) begin
      next_ext_active = 1'b1;
    end else if (next_run) begin
      next_ext_active = 1'b0;
    end
  end

  // Pipe delay rides through an external reset unless tied to power-good
  always @* begin
    next_pipe_rel = pipe_delay_rel;
    if (next_cold) begin
      next_pipe_rel = 1'b0;
    end else if (next_state >= `PRS_ST_POG) begin
      next_pipe_rel = 1'b1;
    end else if (ext_active || ext_entry) begin
      next_pipe_rel = pipe_delay_rel & ~pipe_rst_on_pog;
    end
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state                 <= `PRS_ST_NVM_RST;
      cnt                   <= {CW{1'b0}};
      ext_active            <= 1'b0;
      cfg_load              <= 1'b0;
      cfg_valid             <= 1'b0;
      input_cell_rel        <= 1'b0;
      lut_rel               <= 1'b0;
      store_cell_rel        <= 1'b0;
      pipe_delay_rel        <= 1'b0;
      power_on_good         <= 1'b0;
      vref_drive            <= 1'b0;
      pin_oe_n              <= 1'b1;
      pin_oe_follow         <= 1'b0;
      supply_level_detector <= 1'b0;
      fabric_inverter_a     <= 1'b0;
      fabric_inverter_b     <= 1'b0;
    end else begin
      // Sequencer state and step counter
      state <= next_state;
      cnt   <= next_cnt;
      ext_active <= next_ext_active;
      // External reset keeps configuration; only power loss clears it
      cfg_load  <= (next_state == `PRS_ST_LOAD);
      cfg_valid <= (next_state != `PRS_ST_NVM_RST) &&
                   (next_state != `PRS_ST_LOAD) ;
      // Inputs stay held through the IN step of an external reset, except its first cycle
      input_cell_rel <= (next_state >= `PRS_ST_IN) &&
                        (next_state <= `PRS_ST_RUN) &&
                        !(ext_active && next_state == `PRS_ST_IN) ;
      lut_rel        <= (next_state >= `PRS_ST_LUT) &&
                        (next_state <= `PRS_ST_RUN);
      store_cell_rel <= (next_state >= `PRS_ST_POG) &&
                        (next_state <= `PRS_ST_RUN);
      pipe_delay_rel <= next_pipe_rel;
      power_on_good <= (next_state == `PRS_ST_RUN);
      vref_drive    <= (next_state == `PRS_ST_POG) ||
                       (next_state == `PRS_ST_RUN);
      pin_oe_n      <= ~(next_state == `PRS_ST_RUN);
      // During an external reset the outputs follow their own enables
      pin_oe_follow <= (next_state == `PRS_ST_RUN) ||
                       (ext_active && next_state != `PRS_ST_NVM_RST &&
                        next_state != `PRS_ST_LOAD) ||
                       (state == `PRS_ST_RUN &&
                        next_state == `PRS_ST_IN);
      // Detector reports only while the device runs
      supply_level_detector <= ~supply_det_off &
                               supply_below_2v7 &
                               (next_state == `PRS_ST_RUN);
      // Inverters read low until lookup tables are released
      fabric_inverter_a <= lut_rel & ~inv_a_in;
      fabric_inverter_b <= lut_rel & ~inv_b_in;
    end
  end
endmodule

// >>> dv/prs_props.sv
`timescale 1ns/10ps
module prs_props (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Watched inputs
  input wire supply_on,
  input wire supply_det_off,
  input wire inv_a_in,
  // Watched outputs
  input wire cfg_load,
  input wire cfg_valid,
  input wire input_cell_rel,
  input wire lut_rel,
  input wire store_cell_rel,
  input wire power_on_good,
  input wire vref_drive,
  input wire pin_oe_n,
  input wire supply_level_detector,
  input wire fabric_inverter_a
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_load_held: assert property (cfg_load |-> pin_oe_n && !input_cell_rel)
    else $error("cells released during load");
  a_lut_order: assert property (lut_rel |-> input_cell_rel)
    else $error("lut released before inputs");
  a_store_order: assert property (store_cell_rel |-> lut_rel)
    else $error("storage released before luts");
  a_vref_lead: assert property (
    $rose(power_on_good) |-> $past(vref_drive, 299))
    else $error("reference lead too short");
  a_out_last: assert property (
    !pin_oe_n |-> power_on_good && store_cell_rel)
    else $error("outputs active before power good");
  a_cfg_kept: assert property (
    $fell(power_on_good) && $past(supply_on) |-> cfg_valid)
    else $error("config lost on external reset");
  a_det_off: assert property (supply_det_off |=> !supply_level_detector)
    else $error("detector active while disabled");
  a_inv_a: assert property (lut_rel && $past(lut_rel) |->
    fabric_inverter_a == !$past(inv_a_in))
    else $error("inverter output wrong");
endmodule

// >>> dv/prs_rst_src.sv
`timescale 1ns/10ps
module prs_rst_src (
  // Clock
  input  wire core_clk,
  // Reset pin
  output reg  pin
);
  initial pin = 1'b0;
  // Level changes just after an edge and holds for the given cycles
  task automatic put(input logic v, input int hold);
    @(posedge core_clk);
    pin <= v;
    repeat (hold) @(posedge core_clk);
  endtask
endmodule

// >>> dv/power_on_init_and_external_reset_test.sv
`timescale 1ns/10ps
module power_on_init_and_external_reset_test;
  reg        core_clk = 1'b0, sys_rst = 1'b1, supply_on = 1'b1;
  reg        supply_below_2v7 = 1'b0, supply_det_off = 1'b1, ext_rst_en = 1'b1;
  reg  [1:0] ext_pin_mode = 2'h1, ext_trig_mode = 2'h3;
  reg        pipe_rst_on_pog = 1'b0, inv_a_in = 1'b0, inv_b_in = 1'b0;
  wire       ext_rst_pin, cfg_load, cfg_valid, input_cell_rel, lut_rel;
  wire       store_cell_rel, pipe_delay_rel, power_on_good, vref_drive;
  wire       pin_oe_n, pin_oe_follow, supply_level_detector;
  wire       fabric_inverter_a, fabric_inverter_b;
  integer    fails = 0, checks_done = 0, n, lead;
  always #5 core_clk = ~core_clk;
  prs_rst_src u_src (.core_clk, .pin(ext_rst_pin));
  prs_sequencer #(.LOAD_CYC(4), .STEP_CYC(2)) u_dut (.core_clk, .sys_rst,
    .supply_on, .supply_below_2v7, .supply_det_off, .ext_rst_pin,
    .ext_pin_mode, .ext_rst_en, .ext_trig_mode, .pipe_rst_on_pog, .inv_a_in,
    .inv_b_in, .cfg_load, .cfg_valid, .input_cell_rel, .lut_rel,
    .store_cell_rel, .pipe_delay_rel, .power_on_good, .vref_drive, .pin_oe_n,
    .pin_oe_follow, .supply_level_detector, .fabric_inverter_a,
    .fabric_inverter_b);
  task automatic stop_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Counts reference lead cycles while waiting for power good
  task automatic wait_pog;
    n = 0;
    lead = 0;
    while (power_on_good !== 1'b1) begin
      @(negedge core_clk);
      n = n + 1;
      if (vref_drive === 1'b1 && power_on_good !== 1'b1) lead = lead + 1;
      if (n > 2000) begin
        fails = fails + 1;
        $display("[ERR] %0t wait got %h exp %h", $time,
                 power_on_good, 1'b1);
        stop_test;
      end
    end
  endtask
  task automatic t_power_up;
    @(negedge core_clk);
    @(negedge core_clk);
    chk(cfg_load, 1'b1);
    chk({pin_oe_n, input_cell_rel, fabric_inverter_b}, 3'h4);
    wait_pog;
    chk(lead[15:0], 16'h012c);
    chk({pin_oe_n, cfg_valid, store_cell_rel}, 3'h3);
    @(posedge core_clk);
    inv_a_in <= 1'b1;
    @(negedge core_clk);
    @(negedge core_clk);
    chk({fabric_inverter_a, fabric_inverter_b}, 2'h1);
  endtask
  // Trigger event on the pin; fires only with enable and digital input mode
  task automatic t_ext(input logic [1:0] m, input logic act, en, md);
    @(posedge core_clk);
    ext_trig_mode <= 2'h3;
    pipe_rst_on_pog <= m[0];
    ext_rst_en <= en;
    ext_pin_mode <= {!md, md};
    u_src.put(!act, 2);
    ext_trig_mode <= m;
    u_src.put(act, 1);
    u_src.put(1'b0, 3);
    @(negedge core_clk);
    chk(power_on_good, !(en && md));
    chk({cfg_valid, pin_oe_follow}, 2'h3);
    chk({input_cell_rel, lut_rel, store_cell_rel}, {2'h3, !(en && md)});
    if (en && md) chk(pipe_delay_rel, !m[0]);
    wait_pog;
  endtask
  task automatic t_det(input logic off, below, exp);
    @(posedge core_clk);
    supply_det_off <= off;
    supply_below_2v7 <= below;
    @(negedge core_clk);
    @(negedge core_clk);
    chk(supply_level_detector, exp);
  endtask
  // Supply loss clears configuration and replays the whole sequence
  task automatic t_supply;
    @(posedge core_clk);
    supply_on <= 1'b0;
    @(posedge core_clk);
    supply_on <= 1'b1;
    @(negedge core_clk);
    chk({power_on_good, cfg_valid, pin_oe_n}, 3'h1);
    chk({input_cell_rel, lut_rel, fabric_inverter_a}, 3'h0);
    wait_pog;
    chk(lead[15:0], 16'h012c);
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_power_up;
    t_ext(2'h0, 1'b1, 1'b1, 1'b1);
    t_ext(2'h1, 1'b1, 1'b1, 1'b1);
    t_ext(2'h2, 1'b0, 1'b1, 1'b1);
    t_ext(2'h1, 1'b1, 1'b0, 1'b1);
    t_ext(2'h1, 1'b1, 1'b1, 1'b0);
    t_supply;
    t_det(1'b0, 1'b1, 1'b1);
    t_det(1'b0, 1'b0, 1'b0);
    t_det(1'b1, 1'b1, 1'b0);
    stop_test;
  end
endmodule
bind prs_sequencer prs_props u_props (.core_clk, .sys_rst, .supply_on,
  .supply_det_off, .inv_a_in, .cfg_load, .cfg_valid, .input_cell_rel,
  .lut_rel, .store_cell_rel, .power_on_good, .vref_drive, .pin_oe_n,
  .supply_level_detector, .fabric_inverter_a);
